/* File: rtl/tick_timer_pkg.sv */
// Constants for the low-power down timer: offsets, control fields, reset values.
// Assumes a single system clock with a 32 kHz tick enable made inside the block.
package tick_timer_pkg;
  localparam logic [3:0] OFF_COUNT = 4'h0;
  localparam logic [3:0] OFF_RELOAD = 4'h4;
  localparam logic [3:0] OFF_CONTROL = 4'h8;
  localparam logic [3:0] OFF_SWI = 4'hC;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_RUN = 2;
  localparam int BIT_DBG_EN = 3;
  localparam int BIT_PAUSE = 4;
  localparam int CTRL_W = 5;
  localparam int SWI_W = 4;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
  // Clock and tick rates in Hz
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 32_768;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int DIV_W = 13;
endpackage

/* File: rtl/low_power_down_timer.sv */
// Low-power down timer: 32-bit counter, one-shot or continuous, with pause controls.
// Assumes a simple synchronous register port; debug halt arrives asynchronously.
`timescale 1ns/1ps
`default_nettype none
module low_power_down_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Debug halt from the controller debug logic
  input wire logic debug_halt_in,
  // Power control handshake
  input wire logic lp_request,
  output logic lp_grant,
  // Events
  output logic expiry_irq,
  output logic [3:0] software_irq
);

  logic [31:0] tick_count_reg;
  logic [31:0] tick_reload_reg;
  logic [tick_timer_pkg::CTRL_W-1:0] tick_control_reg;
  logic [tick_timer_pkg::DIV_W-1:0] div_reg;
  logic tick;
  logic [2:0] halt_sync_reg;
  logic halt_reg;
  logic frozen;
  logic step_to_zero;
  logic wr_ctrl;
  logic enabled;
  logic running;

  // Tick enable divider; stands in for the 32 kHz oscillator edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_reg <= '0;
    else if (tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign tick = (32'(div_reg) == tick_timer_pkg::TICK_DIV - 1);

  // Three-stage synchroniser; change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      halt_sync_reg <= 3'h0;
    else
      halt_sync_reg <= {halt_sync_reg[1:0], debug_halt_in};
  end

  // Filtered halt level, read only from the later stages
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      halt_reg <= 1'b0;
    else if (halt_sync_reg[1] == halt_sync_reg[2])
      halt_reg <= halt_sync_reg[2];
  end

  assign enabled = tick_control_reg[tick_timer_pkg::BIT_ENABLE];
  assign running = enabled && tick_control_reg[tick_timer_pkg::BIT_RUN];
  // Either pause source freezes the count in place
  assign frozen = tick_control_reg[tick_timer_pkg::BIT_PAUSE]
    || (tick_control_reg[tick_timer_pkg::BIT_DBG_EN] && halt_reg);
  assign step_to_zero = running && tick && !frozen
    && (tick_count_reg == tick_timer_pkg::COUNT_ONE);
  assign wr_ctrl = reg_wr && (reg_addr == tick_timer_pkg::OFF_CONTROL);

  // Control register; run bit self-clears on start with zero or one-shot expiry
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick_control_reg <= tick_timer_pkg::CTRL_RST;
    else if (wr_ctrl)
    begin
      if (!reg_wdata[tick_timer_pkg::BIT_ENABLE])
        tick_control_reg <= tick_timer_pkg::CTRL_RST;
      else
      begin
        tick_control_reg <= reg_wdata[tick_timer_pkg::CTRL_W-1:0];
        if (reg_wdata[tick_timer_pkg::BIT_RUN] && tick_reload_reg == 32'h0000_0000)
          tick_control_reg[tick_timer_pkg::BIT_RUN] <= 1'b0;
      end
    end
    else if (step_to_zero && !tick_control_reg[tick_timer_pkg::BIT_RELOAD])
      tick_control_reg[tick_timer_pkg::BIT_RUN] <= 1'b0;
  end

  // Reload value register; cleared while the unit is disabled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick_reload_reg <= tick_timer_pkg::RELOAD_RST;
    else if (!enabled && !wr_ctrl)
      tick_reload_reg <= tick_timer_pkg::RELOAD_RST;
    else if (reg_wr && reg_addr == tick_timer_pkg::OFF_RELOAD)
      tick_reload_reg <= reg_wdata;
  end

  // Counter: load on start, decrement per tick, reload or stop at expiry
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick_count_reg <= tick_timer_pkg::COUNT_RST;
    else if (wr_ctrl)
    begin
      if (reg_wdata[tick_timer_pkg::BIT_ENABLE] && reg_wdata[tick_timer_pkg::BIT_RUN])
      begin
        if (!tick_control_reg[tick_timer_pkg::BIT_RUN])
          tick_count_reg <= tick_reload_reg;
      end
      else
        tick_count_reg <= tick_timer_pkg::COUNT_RST;
    end
    else if (!running)
      tick_count_reg <= tick_count_reg;
    else if (step_to_zero)
    begin
      if (tick_control_reg[tick_timer_pkg::BIT_RELOAD])
        tick_count_reg <= tick_reload_reg;
      else
        tick_count_reg <= tick_timer_pkg::COUNT_RST;
    end
    else if (tick && !frozen && tick_count_reg != tick_timer_pkg::COUNT_RST)
      tick_count_reg <= tick_count_reg - 1'b1;
  end

  // Expiry pulse held for one tick period; registered on clk, the only clock, so it needs the core clock running
  logic expiry_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      expiry_reg <= 1'b0;
    else if (step_to_zero)
      expiry_reg <= 1'b1;
    else if (tick)
      expiry_reg <= 1'b0;
  end
  assign expiry_irq = expiry_reg;

  // Software interrupt pulses; writes of zero do nothing
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      software_irq <= 4'h0;
    else if (reg_wr && reg_addr == tick_timer_pkg::OFF_SWI)
      software_irq <= reg_wdata[tick_timer_pkg::SWI_W-1:0];
    else
      software_irq <= 4'h0;
  end

  // Low-power grant only when idle; counting keeps the block awake
  assign lp_grant = lp_request && !running;

  // Read data; count is live and unlatched, so only word reads are coherent
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        tick_timer_pkg::OFF_COUNT: reg_rdata <= tick_count_reg;
        tick_timer_pkg::OFF_RELOAD: reg_rdata <= tick_reload_reg;
        tick_timer_pkg::OFF_CONTROL: reg_rdata <= {27'h0000000, tick_control_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  chk_oneshot_stop: assert property (@(posedge clk) disable iff (!rstn)
    step_to_zero && !tick_control_reg[tick_timer_pkg::BIT_RELOAD] && !wr_ctrl
    |=> tick_count_reg == 32'h0000_0000 && !tick_control_reg[tick_timer_pkg::BIT_RUN])
    else $error("one-shot did not stop");
  chk_reload_value: assert property (@(posedge clk) disable iff (!rstn)
    step_to_zero && tick_control_reg[tick_timer_pkg::BIT_RELOAD] && !wr_ctrl
    |=> tick_count_reg == $past(tick_reload_reg))
    else $error("continuous reload wrong");
  chk_expiry_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(expiry_irq) |-> $past(tick_count_reg) == 32'h0000_0001)
    else $error("expiry without 1-to-0 step");
  chk_pause_freeze: assert property (@(posedge clk) disable iff (!rstn)
    tick_control_reg[tick_timer_pkg::BIT_PAUSE] && !wr_ctrl
    |=> $stable(tick_count_reg))
    else $error("count moved while paused");
  chk_debug_freeze: assert property (@(posedge clk) disable iff (!rstn)
    tick_control_reg[tick_timer_pkg::BIT_DBG_EN] && halt_reg && !wr_ctrl
    |=> $stable(tick_count_reg))
    else $error("count moved during debug halt");
  chk_lp_grant: assert property (@(posedge clk) disable iff (!rstn)
    lp_grant |-> !tick_control_reg[tick_timer_pkg::BIT_RUN] || !enabled)
    else $error("low power granted while counting");
  chk_disable_clear: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && !reg_wdata[tick_timer_pkg::BIT_ENABLE]
    |=> tick_count_reg == 32'h0000_0000 && tick_control_reg == 5'h00
    ##1 tick_reload_reg == 32'h0000_0000)
    else $error("disable did not clear");
  chk_zero_start: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && reg_wdata[tick_timer_pkg::BIT_RUN] && tick_reload_reg == 32'h0000_0000
    |=> !tick_control_reg[tick_timer_pkg::BIT_RUN])
    else $error("start with zero reload ran");
  chk_count_step: assert property (@(posedge clk) disable iff (!rstn)
    running && tick && !frozen && !wr_ctrl && tick_count_reg > 32'h0000_0001
    |=> tick_count_reg == $past(tick_count_reg) - 32'h0000_0001)
    else $error("count did not decrement by one");

  // Tick is a single-cycle enable, never two in a row
  chk_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
    tick
    |=> !tick && div_reg == '0)
    else $error("tick enable lasted more than one cycle");

  // Divider never runs past its terminal count
  chk_div_range: assert property (@(posedge clk) disable iff (!rstn)
    1'b1
    |-> 32'(div_reg) < tick_timer_pkg::TICK_DIV)
    else $error("tick divider out of range");

  // Start from idle copies the reload value into the counter
  chk_start_load: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && reg_wdata[tick_timer_pkg::BIT_ENABLE] && reg_wdata[tick_timer_pkg::BIT_RUN]
    && !tick_control_reg[tick_timer_pkg::BIT_RUN] |=> tick_count_reg == $past(tick_reload_reg))
    else $error("start did not load the reload value");

  // Every 1-to-0 step raises the event on the next cycle
  chk_expiry_set: assert property (@(posedge clk) disable iff (!rstn)
    step_to_zero
    |=> expiry_irq)
    else $error("expiry missing after 1-to-0 step");

  // Pulse ends at the next tick unless a new step restarts it
  chk_expiry_clear: assert property (@(posedge clk) disable iff (!rstn)
    expiry_irq && tick && !step_to_zero
    |=> !expiry_irq)
    else $error("expiry outlived its tick period");

  // Pulse stands for the whole tick period so slow logic can see it
  chk_expiry_hold: assert property (@(posedge clk) disable iff (!rstn)
    expiry_irq && !tick
    |=> expiry_irq)
    else $error("expiry dropped inside its tick period");

  // A stopped one-shot must not move on its own
  chk_idle_hold: assert property (@(posedge clk) disable iff (!rstn)
    !running && !wr_ctrl
    |=> $stable(tick_count_reg))
    else $error("idle counter moved");

  // A frozen counter can never produce an event
  chk_frozen_quiet: assert property (@(posedge clk) disable iff (!rstn)
    frozen && !wr_ctrl
    |=> !$rose(expiry_irq))
    else $error("expiry while frozen");

  // Clearing run zeroes the counter
  chk_run_stop: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && reg_wdata[tick_timer_pkg::BIT_ENABLE] && !reg_wdata[tick_timer_pkg::BIT_RUN]
    |=> tick_count_reg == tick_timer_pkg::COUNT_RST)
    else $error("run clear left a count");

  // Count reads return the live value of the cycle they were asked in
  chk_count_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == tick_timer_pkg::OFF_COUNT
    |=> reg_rdata == $past(tick_count_reg))
    else $error("count read mismatch");

  // Control reads show the field layout as stored
  chk_ctrl_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == tick_timer_pkg::OFF_CONTROL
    |=> reg_rdata[tick_timer_pkg::CTRL_W-1:0] == $past(tick_control_reg))
    else $error("control read mismatch");

  // Software interrupt bits follow the written ones for one cycle
  chk_swi_write: assert property (@(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == tick_timer_pkg::OFF_SWI
    |=> software_irq == $past(reg_wdata[tick_timer_pkg::SWI_W-1:0]))
    else $error("software interrupt not raised");

  // Without a write the software interrupt lines stay low
  chk_swi_idle: assert property (@(posedge clk) disable iff (!rstn)
    !(reg_wr && reg_addr == tick_timer_pkg::OFF_SWI)
    |=> software_irq == 4'h0)
    else $error("software interrupt without write");

  // Halt level moves only when the last two stages agreed
  chk_halt_filter: assert property (@(posedge clk) disable iff (!rstn)
    $changed(halt_reg)
    |-> $past(halt_sync_reg[1]) == $past(halt_sync_reg[2]))
    else $error("halt changed on an unsettled sample");

  // Reload writes stick only while the unit is enabled
  chk_reload_write: assert property (@(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == tick_timer_pkg::OFF_RELOAD && enabled
    |=> tick_reload_reg == $past(reg_wdata))
    else $error("reload write lost");

  // Disabled unit keeps its reload register at default
  chk_disabled_reload: assert property (@(posedge clk) disable iff (!rstn)
    !enabled && !wr_ctrl
    |=> tick_reload_reg == tick_timer_pkg::RELOAD_RST)
    else $error("reload kept while disabled");

  // An idle timer must let the power controller in
  chk_lp_free: assert property (@(posedge clk) disable iff (!rstn)
    lp_request && !running
    |-> lp_grant)
    else $error("low power refused while idle");

endmodule
`default_nettype wire

/* File: tb/low_power_down_timer_tb.sv */
// Self-checking bench for the low-power down timer: register port, expiry, pauses.
// Assumes tick_timer_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module low_power_down_timer_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic debug_halt_in = 1'b0;
  logic lp_request = 1'b0;
  logic lp_grant;
  logic expiry_irq;
  logic [3:0] software_irq;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int m_reload;
  int n;
  logic [31:0] d;
  localparam int TD = tick_timer_pkg::TICK_DIV;

  low_power_down_timer u_low_power_down_timer (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .debug_halt_in(debug_halt_in), .lp_request(lp_request), .lp_grant(lp_grant),
    .expiry_irq(expiry_irq), .software_irq(software_irq));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Hang guard at about twelve tick periods, a few above the nine or so ticks the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; effect is settled by the following negedge
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  // Expiry must come within a few ticks and stand exactly one tick period
  task automatic wait_exp();
    n = 0;
    while (expiry_irq !== 1'b1 && n < 4 * TD)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, expiry_irq}, 32'h1);
    n = 0;
    while (expiry_irq === 1'b1 && n < 2 * TD)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, TD);
  endtask

  // Over a full tick period no expiry may appear
  task automatic quiet();
    n = 0;
    repeat (TD + 20)
    begin
      @(negedge clk);
      if (expiry_irq !== 1'b0)
        n++;
    end
    chk(n, 0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    void'($urandom(93922));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(tick_timer_pkg::OFF_COUNT, 32'h0);
    rd(tick_timer_pkg::OFF_RELOAD, 32'h0);
    rd(tick_timer_pkg::OFF_CONTROL, 32'h0);
    // One-shot; enable first, since a disabled unit drops reload register writes
    m_reload = 2;
    wr(tick_timer_pkg::OFF_CONTROL, 32'h1);
    wr(tick_timer_pkg::OFF_RELOAD, m_reload);
    wr(tick_timer_pkg::OFF_CONTROL, 32'h5);
    rd(tick_timer_pkg::OFF_COUNT, m_reload);
    @(posedge clk);
    lp_request <= 1'b1;
    @(negedge clk);
    chk({31'h0, lp_grant}, 32'h0);
    wait_exp();
    rd(tick_timer_pkg::OFF_COUNT, 32'h0);
    rd(tick_timer_pkg::OFF_CONTROL, 32'h1);
    chk({31'h0, lp_grant}, 32'h1);
    // Continuous; reload 2 keeps pulses apart, one tick has passed at the read
    m_reload = 2;
    wr(tick_timer_pkg::OFF_RELOAD, m_reload);
    wr(tick_timer_pkg::OFF_CONTROL, 32'h7);
    wait_exp();
    rd(tick_timer_pkg::OFF_COUNT, m_reload - 1);
    rd(tick_timer_pkg::OFF_CONTROL, 32'h7);
    wr(tick_timer_pkg::OFF_CONTROL, 32'h3);
    rd(tick_timer_pkg::OFF_COUNT, 32'h0);
    quiet();
    // Start with zero reload is refused
    wr(tick_timer_pkg::OFF_RELOAD, 32'h0);
    wr(tick_timer_pkg::OFF_CONTROL, 32'h5);
    rd(tick_timer_pkg::OFF_CONTROL, 32'h1);
    // Software pause, then debug halt takes over the freeze
    @(posedge clk);
    debug_halt_in <= 1'b1;
    wr(tick_timer_pkg::OFF_RELOAD, 32'h3);
    wr(tick_timer_pkg::OFF_CONTROL, 32'h15);
    quiet();
    rd(tick_timer_pkg::OFF_COUNT, 32'h3);
    wr(tick_timer_pkg::OFF_CONTROL, 32'hD);
    quiet();
    rd(tick_timer_pkg::OFF_COUNT, 32'h3);
    // Disabling the unit clears the count, reload and control registers
    wr(tick_timer_pkg::OFF_CONTROL, 32'h0);
    rd(tick_timer_pkg::OFF_COUNT, 32'h0);
    rd(tick_timer_pkg::OFF_RELOAD, 32'h0);
    d = $urandom;
    wr(tick_timer_pkg::OFF_SWI, d);
    chk({28'h0, software_irq}, {28'h0, d[3:0]});
    rd(4'($urandom_range(1, 3)), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
